// File: core/isb_fifo_top.sv
// What this block does
// - three-bit field selects one of six modes
// - bypass stores nothing, buffer stays empty
// - bypass clears; fill-and-stop restarts from empty
// - fill-and-stop appends until full, then stops
// - 3 kbytes; halt-at-watermark limits depth
// - continuous always accepts, oldest word discarded
// - watermark flag when unread count reaches level
// - watermark flag routed to enabled pins
// - full indication routed to enabled pins
// - overrun flag once oldest word overwritten
// - ten-bit unread word count in status
// - status shows full and empty too
// - continuous until trigger, then fill-and-stop
// - bypass until trigger, then continuous
// - bypass until trigger, then fill-and-stop
// - tag at 78h, six data bytes follow
// - words written on data-ready events and on logged rate changes
// - timestamp words decimated by 1, 8, 32
// - per-sensor independent batching rates
// - batch event counter with ten-bit threshold
// - batch-count flag routed to enabled pins
// - rate changes logged with config and timestamp
`timescale 1ns/1ps
`default_nettype none

module isb_fifo_top
    import isb_pkg::*;
(
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    input  wire logic [6:0]  REG_ADDR_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    input  wire logic [7:0]  REG_WDATA_I,
    output logic      [7:0]  REG_RDATA_O,
    input  wire logic        ACC_DRDY_I,
    input  wire logic        GYR_DRDY_I,
    input  var  isb_sample_type SAMPLE_I,
    input  wire logic [31:0] TS_VALUE_I,
    input  wire logic [1:0]  ACC_RATE_SEL_I,
    input  wire logic [1:0]  GYR_RATE_SEL_I,
    input  wire logic [1:0]  TEMP_RATE_SEL_I,
    input  wire logic        RATE_CHG_I,
    input  wire logic [7:0]  RATE_CFG_I,
    input  wire logic        WAKEUP_EVT_I,
    input  wire logic        FREEFALL_EVT_I,
    input  wire logic        ORIENTATION_EVT_I,
    input  wire logic [1:0]  TRIG_SEL_I,
    output logic             INTERRUPT_PIN_ONE_O,
    output logic             INTERRUPT_PIN_TWO_O
);

    // decimation: 0 off, n stores every 2^(n-1)th event
    function automatic logic rate_hit(input logic [2:0] cnt,
                                      input logic [1:0] sel);
        logic [2:0] mask;
        mask = (sel == 2'h3) ? 3'h3 : (sel == 2'h2) ? 3'h1 : 3'h0;
        return (sel != 2'h0) && ((cnt & mask) == 3'h0);
    endfunction

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction

    // host-written registers
    logic [7:0] wm_low_r;
    logic [7:0] wm_high_r;
    logic [7:0] mode_reg_r;
    logic [7:0] cnt_a_r;
    logic [7:0] cnt_b_r;
    logic [7:0] route_one_r;
    logic [7:0] route_two_r;

    // buffer state
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic             overrun_r;
    logic             batch_flag_r;
    logic [CNT_W-1:0] batch_cnt_r;
    logic [2:0]       acc_div_r;
    logic [2:0]       gyr_div_r;
    logic [2:0]       temp_div_r;
    logic [4:0]       ts_div_r;
    logic [NSRC-1:0]  pend_r;
    isb_word_type     pend_word_r [NSRC];
    logic [7:0]       rdata_r;
    logic             int_one_r;
    logic             int_two_r;

    wire logic [8:0] watermark_level = {wm_high_r[WM_HIGH_BIT], wm_low_r};
    wire logic halt_at_watermark = wm_high_r[HALT_WM_BIT];
    wire logic rate_change_log_en = wm_high_r[RATE_LOG_BIT];
    wire logic [2:0] mode = mode_reg_r[MODE_LSB +: 3];
    wire logic [1:0] ts_dec = mode_reg_r[TS_DEC_LSB +: 2];
    wire logic [9:0] batch_count_limit =
        {cnt_a_r[LIMIT_HIGH_LSB +: 2], cnt_b_r};
    wire logic batch_count_source = cnt_a_r[CNT_SOURCE_BIT];

    // selected motion trigger
    wire logic trig = (TRIG_SEL_I == 2'h0) ? WAKEUP_EVT_I :
                      (TRIG_SEL_I == 2'h1) ? FREEFALL_EVT_I :
                      (TRIG_SEL_I == 2'h2) ? ORIENTATION_EVT_I : 1'b0;

    // effective behaviour per mode; unknown codes act as bypass
    logic eff_bypass;
    logic eff_cont;
    always_comb
    begin
        eff_bypass = 1'b0;
        eff_cont   = 1'b0;
        unique case (mode)
            MODE_BYPASS:      eff_bypass = 1'b1;
            MODE_FILL_STOP:   eff_cont   = 1'b0;
            MODE_CONT:        eff_cont   = 1'b1;
            MODE_CONT_STOP:   eff_cont   = !trig;
            MODE_BYPASS_CONT:
            begin
                eff_bypass = !trig;
                eff_cont   = trig;
            end
            MODE_BYPASS_STOP: eff_bypass = !trig;
            default:          eff_bypass = 1'b1;
        endcase
    end

    // depth limit: full capacity or the watermark level
    wire logic [CNT_W-1:0] limit = halt_at_watermark ?
        {1'b0, watermark_level} : DEPTH_CNT;

    // batching events, one per enabled sensor data-ready
    wire logic acc_evt = ACC_DRDY_I && rate_hit(acc_div_r,
                                                ACC_RATE_SEL_I);
    wire logic gyr_evt = GYR_DRDY_I && rate_hit(gyr_div_r,
                                                GYR_RATE_SEL_I);
    wire logic any_drdy = ACC_DRDY_I || GYR_DRDY_I;
    wire logic temp_evt = any_drdy && rate_hit(temp_div_r,
                                               TEMP_RATE_SEL_I);
    wire logic batch_evt = acc_evt || gyr_evt;
    wire logic [4:0] ts_mask = (ts_dec == 2'h1) ? TS_MASK_1 :
                               (ts_dec == 2'h2) ? TS_MASK_8 : TS_MASK_32;
    wire logic ts_evt = batch_evt && (ts_dec != 2'h0)
                        && ((ts_div_r & ts_mask) == 5'h00);
    wire logic cfg_evt = RATE_CHG_I && rate_change_log_en;

    wire logic [NSRC-1:0] evt = {cfg_evt, ts_evt, temp_evt,
                                 acc_evt, gyr_evt};
    isb_word_type evt_word [NSRC];
    assign evt_word[0] = '{tag: TAG_GYR,  data: SAMPLE_I.gyr};
    assign evt_word[1] = '{tag: TAG_ACC,  data: SAMPLE_I.acc};
    assign evt_word[2] = '{tag: TAG_TEMP, data: SAMPLE_I.temp};
    assign evt_word[3] = '{tag: TAG_TS,   data: {16'h0000, TS_VALUE_I}};
    assign evt_word[4] = '{tag: TAG_CFG,
                           data: {8'h00, RATE_CFG_I, TS_VALUE_I}};

    // one word a cycle; lowest index pending first
    logic [2:0] sel_idx;
    always_comb
    begin
        sel_idx = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (pend_r[i])
                sel_idx = 3'(i);
        end
    end

    wire logic pop = REG_RD_I && (REG_ADDR_I == ADDR_DATA5)
                     && (count_r != '0);
    wire logic [CNT_W-1:0] count_after_pop =
        count_r - CNT_W'(pop);
    wire logic room = count_after_pop < limit;
    wire logic serve = (|pend_r) && !eff_bypass;
    wire logic do_write = serve && (room || eff_cont);
    wire logic discard = do_write && !room;
    wire logic [NSRC-1:0] taken = serve ?
        NSRC'(5'h01 << sel_idx) : '0;

    wire logic [CNT_W-1:0] count_nxt =
        count_after_pop + CNT_W'(do_write && !discard);

    isb_word_type head_word;
    isb_word_store u_store
    (
        .clk_i   (REF_CLK_I),
        .rst_i   (RST_I),
        .we_i    (do_write),
        .waddr_i (wr_ptr_r),
        .wdata_i (pend_word_r[sel_idx]),
        .raddr_i ((pop || discard) ? ptr_inc(rd_ptr_r) : rd_ptr_r),
        .q_o     (head_word)
    );

    // status, recomputed from the live count
    wire logic watermark_flag = count_r >= {1'b0, watermark_level};
    wire logic full_flag = count_r >= limit;
    wire logic empty_flag = count_r == '0;
    wire logic [7:0] stat_high =
        (8'(watermark_flag) << STAT_WM_BIT)
        | (8'(overrun_r) << STAT_OVR_BIT)
        | (8'(full_flag) << STAT_FULL_BIT)
        | (8'(empty_flag) << STAT_EMPTY_BIT)
        | (8'(batch_flag_r) << STAT_CNT_FLAG_BIT)
        | (8'(count_r[9:8]) << STAT_CNT_HIGH_LSB);

    // register read decode
    wire logic in_data = (REG_ADDR_I >= ADDR_DATA0)
                         && (REG_ADDR_I <= ADDR_DATA5);
    wire logic [2:0] byte_idx = 3'(REG_ADDR_I - ADDR_DATA0);
    wire logic [7:0] data_byte = head_word.data[8 * byte_idx +: 8];
    wire logic [7:0] rd_mux =
        (REG_ADDR_I == ADDR_WM_LOW)    ? wm_low_r :
        (REG_ADDR_I == ADDR_WM_HIGH)   ? wm_high_r :
        (REG_ADDR_I == ADDR_MODE)      ? mode_reg_r :
        (REG_ADDR_I == ADDR_CNT_A)     ? cnt_a_r :
        (REG_ADDR_I == ADDR_CNT_B)     ? cnt_b_r :
        (REG_ADDR_I == ADDR_ROUTE_ONE) ? route_one_r :
        (REG_ADDR_I == ADDR_ROUTE_TWO) ? route_two_r :
        (REG_ADDR_I == ADDR_STAT_LOW)  ? count_r[7:0] :
        (REG_ADDR_I == ADDR_STAT_HIGH) ? stat_high :
        (REG_ADDR_I == ADDR_TAG)       ? head_word.tag :
        in_data                        ? data_byte : 8'h00;

    wire logic wr_en = REG_WR_I;

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            wm_low_r    <= REG_RESET;
            wm_high_r   <= REG_RESET;
            mode_reg_r  <= REG_RESET;
            cnt_a_r     <= REG_RESET;
            cnt_b_r     <= REG_RESET;
            route_one_r <= REG_RESET;
            route_two_r <= REG_RESET;
        end
        else if (wr_en)
        begin
            if (REG_ADDR_I == ADDR_WM_LOW)    wm_low_r    <= REG_WDATA_I;
            if (REG_ADDR_I == ADDR_WM_HIGH)   wm_high_r   <= REG_WDATA_I;
            if (REG_ADDR_I == ADDR_MODE)      mode_reg_r  <= REG_WDATA_I;
            if (REG_ADDR_I == ADDR_CNT_A)     cnt_a_r     <= REG_WDATA_I;
            if (REG_ADDR_I == ADDR_CNT_B)     cnt_b_r     <= REG_WDATA_I;
            if (REG_ADDR_I == ADDR_ROUTE_ONE) route_one_r <= REG_WDATA_I;
            if (REG_ADDR_I == ADDR_ROUTE_TWO) route_two_r <= REG_WDATA_I;
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
            rdata_r <= 8'h00;
        else if (REG_RD_I)
            rdata_r <= rd_mux;
    end
    assign REG_RDATA_O = rdata_r;

    // pointers and count; bypass holds the buffer reset
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I || eff_bypass)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (do_write)
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            if (pop || discard)
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            count_r <= count_nxt;
        end
    end

    // overrun: set on discard, cleared once a word is read or on bypass;
    // a new discard wins over the clear
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I || eff_bypass)
            overrun_r <= 1'b0;
        else if (discard)
            overrun_r <= 1'b1;
        else if (pop)
            overrun_r <= 1'b0;
    end

    // pending words: a new event beats the take in the same cycle
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I || eff_bypass)
            pend_r <= '0;
        else
            pend_r <= (pend_r & ~taken) | evt;
    end

    always_ff @(posedge REF_CLK_I)
    begin
        for (int i = 0; i < NSRC; i++)
        begin
            if (RST_I)
                pend_word_r[i] <= '0;
            else if (evt[i])
                pend_word_r[i] <= evt_word[i];
        end
    end

    // per-sensor decimation counters
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            acc_div_r  <= '0;
            gyr_div_r  <= '0;
            temp_div_r <= '0;
            ts_div_r   <= '0;
        end
        else
        begin
            if (ACC_DRDY_I) acc_div_r  <= acc_div_r + 3'h1;
            if (GYR_DRDY_I) gyr_div_r  <= gyr_div_r + 3'h1;
            if (any_drdy)   temp_div_r <= temp_div_r + 3'h1;
            if (batch_evt)  ts_div_r   <= ts_div_r + 5'h01;
        end
    end

    // batch counter of one sensor; flag clears on status read,
    // but a new hit in that cycle keeps it set
    wire logic cnt_evt = batch_count_source ? gyr_evt : acc_evt;
    wire logic cnt_hit = cnt_evt && (batch_count_limit != 10'h000)
        && (batch_cnt_r + 10'h001 >= batch_count_limit);
    wire logic stat_read = REG_RD_I && (REG_ADDR_I == ADDR_STAT_HIGH);

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            batch_cnt_r  <= '0;
            batch_flag_r <= 1'b0;
        end
        else
        begin
            if (cnt_hit)
                batch_cnt_r <= '0;
            else if (cnt_evt)
                batch_cnt_r <= batch_cnt_r + 10'h001;
            if (cnt_hit)
                batch_flag_r <= 1'b1;
            else if (stat_read)
                batch_flag_r <= 1'b0;
        end
    end

    // interrupt routing, registered so pins never glitch
    wire logic [7:0] live_src = (8'(watermark_flag) << ROUTE_WM_BIT)
                              | (8'(batch_flag_r) << ROUTE_CNT_BIT)
                              | (8'(full_flag) << ROUTE_FULL_BIT);

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            int_one_r <= 1'b0;
            int_two_r <= 1'b0;
        end
        else
        begin
            int_one_r <= |(live_src & route_one_r);
            int_two_r <= |(live_src & route_two_r);
        end
    end
    assign INTERRUPT_PIN_ONE_O = int_one_r;
    assign INTERRUPT_PIN_TWO_O = int_two_r;

endmodule

`default_nettype wire

// File: core/isb_pkg.sv
package isb_pkg;

    // register map, 7-bit register addresses
    localparam logic [6:0] ADDR_WM_LOW     = 7'h07;
    localparam logic [6:0] ADDR_WM_HIGH    = 7'h08;
    localparam logic [6:0] ADDR_MODE       = 7'h0a;
    localparam logic [6:0] ADDR_CNT_A      = 7'h0b;
    localparam logic [6:0] ADDR_CNT_B      = 7'h0c;
    localparam logic [6:0] ADDR_ROUTE_ONE  = 7'h0d;
    localparam logic [6:0] ADDR_ROUTE_TWO  = 7'h0e;
    localparam logic [6:0] ADDR_STAT_LOW   = 7'h3a;
    localparam logic [6:0] ADDR_STAT_HIGH  = 7'h3b;
    localparam logic [6:0] ADDR_TAG        = 7'h78;
    localparam logic [6:0] ADDR_DATA0      = 7'h79;
    localparam logic [6:0] ADDR_DATA5      = 7'h7e;

    // field positions
    localparam int WM_HIGH_BIT       = 0;
    localparam int RATE_LOG_BIT      = 4;
    localparam int HALT_WM_BIT       = 7;
    localparam int MODE_LSB          = 0;
    localparam int TS_DEC_LSB        = 6;
    localparam int LIMIT_HIGH_LSB    = 0;
    localparam int CNT_SOURCE_BIT    = 5;
    localparam int ROUTE_WM_BIT      = 3;
    localparam int ROUTE_CNT_BIT     = 4;
    localparam int ROUTE_FULL_BIT    = 5;
    localparam int STAT_CNT_HIGH_LSB = 0;
    localparam int STAT_CNT_FLAG_BIT = 3;
    localparam int STAT_EMPTY_BIT    = 4;
    localparam int STAT_FULL_BIT     = 5;
    localparam int STAT_OVR_BIT      = 6;
    localparam int STAT_WM_BIT       = 7;

    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    // mode codes
    localparam logic [2:0] MODE_BYPASS      = 3'h0;
    localparam logic [2:0] MODE_FILL_STOP   = 3'h1;
    localparam logic [2:0] MODE_CONT_STOP   = 3'h3;
    localparam logic [2:0] MODE_BYPASS_CONT = 3'h4;
    localparam logic [2:0] MODE_CONT        = 3'h6;
    localparam logic [2:0] MODE_BYPASS_STOP = 3'h7;

    // capacity: 3 kbytes of seven-byte words
    localparam int CAP_BYTES  = 3072;
    localparam int WORD_BYTES = 7;
    localparam int DEPTH      = CAP_BYTES / WORD_BYTES;
    localparam int PTR_W      = 9;
    localparam int CNT_W      = 10;
    localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(DEPTH);

    // word tags
    localparam logic [7:0] TAG_GYR  = 8'h08;
    localparam logic [7:0] TAG_ACC  = 8'h10;
    localparam logic [7:0] TAG_TEMP = 8'h18;
    localparam logic [7:0] TAG_TS   = 8'h20;
    localparam logic [7:0] TAG_CFG  = 8'h28;

    // timestamp decimation masks for factors 1, 8, 32
    localparam logic [4:0] TS_MASK_1  = 5'h00;
    localparam logic [4:0] TS_MASK_8  = 5'h07;
    localparam logic [4:0] TS_MASK_32 = 5'h1f;

    localparam int NSRC = 5;

    typedef struct packed {
        logic [7:0]  tag;
        logic [47:0] data;
    } isb_word_type;

    typedef struct packed {
        logic [47:0] acc;
        logic [47:0] gyr;
        logic [47:0] temp;
    } isb_sample_type;

endpackage

// File: core/isb_word_store.sv
`timescale 1ns/1ps
`default_nettype none

module isb_word_store
    import isb_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             we_i,
    input  wire logic [PTR_W-1:0] waddr_i,
    input  var  isb_word_type     wdata_i,
    input  wire logic [PTR_W-1:0] raddr_i,
    output var  isb_word_type     q_o
);

    isb_word_type mem [DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
            mem[waddr_i] <= wdata_i;
    end

    // write-first so a word landing at the head is visible at once
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q_o <= '0;
        else if (we_i && (waddr_i == raddr_i))
            q_o <= wdata_i;
        else
            q_o <= mem[raddr_i];
    end

endmodule

`default_nettype wire

// File: verif/isb_fifo_props.sv
`timescale 1ns/1ps
`default_nettype none

module isb_fifo_props
    import isb_pkg::*;
(
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_I,
    input  wire logic [6:0] REG_ADDR_I,
    input  wire logic       REG_WR_I,
    input  wire logic       REG_RD_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic [7:0] REG_RDATA_O,
    input  wire logic       INTERRUPT_PIN_ONE_O,
    input  wire logic       INTERRUPT_PIN_TWO_O
);
    // shadow of host writes, so read-back can be judged
    logic [7:0] wm_r;
    logic [7:0] lim_r;
    logic [7:0] r1_r;
    logic [7:0] r2_r;
    logic [2:0] mode_r;
    logic [1:0] byp_r;
    logic       byp_ok;
    assign byp_ok = (byp_r == 2'h3);

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            wm_r   <= 8'h00;
            lim_r  <= 8'h00;
            r1_r   <= 8'h00;
            r2_r   <= 8'h00;
            mode_r <= 3'h0;
        end
        else if (REG_WR_I)
        begin
            if (REG_ADDR_I == ADDR_WM_LOW) wm_r <= REG_WDATA_I;
            if (REG_ADDR_I == ADDR_CNT_B) lim_r <= REG_WDATA_I;
            if (REG_ADDR_I == ADDR_ROUTE_ONE) r1_r <= REG_WDATA_I;
            if (REG_ADDR_I == ADDR_ROUTE_TWO) r2_r <= REG_WDATA_I;
            if (REG_ADDR_I == ADDR_MODE) mode_r <= REG_WDATA_I[2:0];
        end
    end

    // settle time: a word already in flight may still land after the switch
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I || mode_r != MODE_BYPASS)
            byp_r <= 2'h0;
        else if (!byp_ok)
            byp_r <= byp_r + 2'h1;
    end

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);

    AST_RDATA_HOLDS: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
        else $error("read data changed with no read");
    AST_UNMAPPED_ZERO: assert property (REG_RD_I && REG_ADDR_I == 7'h7f
        |=> REG_RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    AST_PIN_ONE_IDLE: assert property (r1_r[5:3] == 3'h0
        && $past(r1_r[5:3]) == 3'h0 |-> !INTERRUPT_PIN_ONE_O)
        else $error("pin one high with nothing routed");
    AST_PIN_TWO_IDLE: assert property (r2_r[5:3] == 3'h0
        && $past(r2_r[5:3]) == 3'h0 |-> !INTERRUPT_PIN_TWO_O)
        else $error("pin two high with nothing routed");
    AST_BYPASS_COUNT: assert property (byp_ok && REG_RD_I
        && REG_ADDR_I == ADDR_STAT_LOW |=> REG_RDATA_O == 8'h00)
        else $error("count not zero in bypass");
    AST_BYPASS_STATUS: assert property (byp_ok && REG_RD_I
        && REG_ADDR_I == ADDR_STAT_HIGH
        |=> REG_RDATA_O[4] && REG_RDATA_O[6] == 1'b0
        && REG_RDATA_O[1:0] == 2'h0)
        else $error("bypass status not empty");
    AST_WM_READBACK: assert property (REG_RD_I && REG_ADDR_I == ADDR_WM_LOW
        |=> REG_RDATA_O == $past(wm_r))
        else $error("watermark level read-back wrong");
    AST_LIMIT_READBACK: assert property (REG_RD_I && REG_ADDR_I == ADDR_CNT_B
        |=> REG_RDATA_O == $past(lim_r))
        else $error("batch limit read-back wrong");

    cover property (REG_RD_I && REG_ADDR_I == ADDR_DATA5);
    cover property (INTERRUPT_PIN_ONE_O);
    cover property (INTERRUPT_PIN_TWO_O);
endmodule

bind isb_fifo_top isb_fifo_props i_isb_fifo_props (
    .REF_CLK_I          (REF_CLK_I),
    .RST_I              (RST_I),
    .REG_ADDR_I         (REG_ADDR_I),
    .REG_WR_I           (REG_WR_I),
    .REG_RD_I           (REG_RD_I),
    .REG_WDATA_I        (REG_WDATA_I),
    .REG_RDATA_O        (REG_RDATA_O),
    .INTERRUPT_PIN_ONE_O(INTERRUPT_PIN_ONE_O),
    .INTERRUPT_PIN_TWO_O(INTERRUPT_PIN_TWO_O)
);

`default_nettype wire

// File: verif/isb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module isb_host_model
    import isb_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output var  logic [6:0] addr_o,
    output var  logic       wr_o,
    output var  logic       rd_o,
    output var  logic [7:0] wdata_o
);
    initial
    begin
        addr_o = 7'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end

    // released lines show the inverse, never a stale copy
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        d = rdata_i;
        rd_o = 1'b0;
        addr_o = ~addr_o;
    endtask
endmodule

`default_nettype wire

// File: verif/test_inertial_sample_batching_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module test_inertial_sample_batching_fifo
    import isb_pkg::*;
;
    logic           clk, rst, wr, rd, acc, gyr, wake, fall, ori, p1, p2, chg;
    logic [6:0]     addr;
    logic [7:0]     wd, rdata, hi;
    logic [1:0]     tsel, asel;
    logic [31:0]    ts;
    isb_sample_type smp;
    int             bad_count, tests_run, cycles;

    isb_fifo_top i_isb_fifo_top (
        .REF_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wd),
        .REG_RDATA_O(rdata), .ACC_DRDY_I(acc), .GYR_DRDY_I(gyr),
        .SAMPLE_I(smp), .TS_VALUE_I(ts), .ACC_RATE_SEL_I(asel),
        .GYR_RATE_SEL_I(2'h1), .TEMP_RATE_SEL_I(2'h0), .RATE_CHG_I(chg),
        .RATE_CFG_I(8'h00), .WAKEUP_EVT_I(wake), .FREEFALL_EVT_I(fall),
        .ORIENTATION_EVT_I(ori), .TRIG_SEL_I(tsel),
        .INTERRUPT_PIN_ONE_O(p1), .INTERRUPT_PIN_TWO_O(p2)
    );
    isb_host_model i_isb_host_model (
        .clk_i(clk), .rdata_i(rdata), .addr_o(addr),
        .wr_o(wr), .rd_o(rd), .wdata_o(wd)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // a hang is cut short well above the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [6:0] a, input logic [7:0] d);
        i_isb_host_model.wr(a, d);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_isb_host_model.rd(a, d);
        chk({2'h0, d}, {2'h0, exp});
    endtask
    task automatic cnt(input logic [9:0] exp);
        logic [7:0] lo;
        i_isb_host_model.rd(ADDR_STAT_LOW, lo);
        i_isb_host_model.rd(ADDR_STAT_HIGH, hi);
        chk({hi[1:0], lo}, exp);
    endtask
    // gyro byte k carries v+k, so byte order shows in the read-out
    task automatic pulse(input logic a, input logic g, input logic [7:0] v);
        @(posedge clk);
        #1;
        smp = {{6{v}}, {6{v}} + 48'h050403020100, 48'h0};
        acc = a;
        gyr = g;
        @(posedge clk);
        #1;
        acc = 1'b0;
        gyr = 1'b0;
        repeat (3) @(posedge clk);
        // step off the edge so pins are read settled
        #1;
    endtask
    task automatic rword(input logic [7:0] tag, input logic [7:0] v, int s);
        rdc(ADDR_TAG, tag);
        for (int k = 0; k < 6; k++)
            rdc(ADDR_DATA0 + 7'(k), v + 8'(k * s));
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
    endtask

    task automatic t_reset();
        rdc(ADDR_MODE, 8'h00);
        rdc(7'h7f, 8'h00);
        rdc(ADDR_WM_LOW, 8'h00);
        rdc(ADDR_CNT_B, 8'h00);
        pulse(1'b1, 1'b1, 8'h11);
        cnt(10'h000);
        chk({9'h0, hi[4]}, 10'h001);
    endtask
    task automatic t_fill();
        w(ADDR_WM_LOW, 8'h03);
        w(ADDR_WM_HIGH, 8'h80);
        w(ADDR_ROUTE_ONE, 8'h20);
        w(ADDR_ROUTE_TWO, 8'h08);
        w(ADDR_MODE, {5'h0, MODE_FILL_STOP});
        cnt(10'h000);
        pulse(1'b1, 1'b1, 8'h20);
        pulse(1'b1, 1'b0, 8'h30);
        pulse(1'b1, 1'b0, 8'h40);
        chk({8'h0, p1, p2}, 10'h003);
        cnt(10'h003);
        chk({8'h0, hi[7], hi[5]}, 10'h003);
        rword(TAG_GYR, 8'h20, 1);
        cnt(10'h002);
        chk({7'h0, hi[7], p1, p2}, 10'h000);
        w(ADDR_MODE, {5'h0, MODE_BYPASS});
        cnt(10'h000);
        w(ADDR_MODE, {5'h0, MODE_FILL_STOP});
        pulse(1'b1, 1'b0, 8'h50);
        cnt(10'h001);
    endtask
    task automatic t_cont();
        w(ADDR_MODE, {5'h0, MODE_BYPASS});
        w(ADDR_MODE, {5'h0, MODE_CONT});
        for (int i = 1; i < 6; i++)
            pulse(1'b1, 1'b0, 8'(i));
        cnt(10'h003);
        chk({9'h0, hi[6]}, 10'h001);
        rword(TAG_ACC, 8'h03, 0);
    endtask
    task automatic t_trig();
        logic [2:0] md [3];
        logic [9:0] e0 [3];
        md = '{MODE_CONT_STOP, MODE_BYPASS_CONT, MODE_BYPASS_STOP};
        e0 = '{10'h1, 10'h0, 10'h0};
        for (int i = 0; i < 3; i++)
        begin
            w(ADDR_MODE, {5'h0, MODE_BYPASS});
            tsel = 2'(i);
            w(ADDR_MODE, {5'h0, md[i]});
            pulse(1'b1, 1'b0, 8'h60);
            cnt(e0[i]);
            {ori, fall, wake} = 3'h1 << i;
            pulse(1'b1, 1'b0, 8'h61);
            cnt(e0[i] + 10'h1);
            {ori, fall, wake} = 3'h0;
        end
    endtask
    task automatic t_batch();
        do_reset();
        w(ADDR_ROUTE_ONE, 8'h10);
        w(ADDR_CNT_B, 8'h02);
        rdc(ADDR_CNT_B, 8'h02);
        w(ADDR_MODE, {5'h0, MODE_CONT});
        pulse(1'b1, 1'b0, 8'h70);
        chk({9'h0, p1}, 10'h000);
        pulse(1'b1, 1'b0, 8'h71);
        chk({9'h0, p1}, 10'h001);
        cnt(10'h002);
        chk({9'h0, hi[3]}, 10'h001);
    endtask
    // acc divider stands at 2 here, so one in four hits once
    task automatic t_rate();
        w(ADDR_MODE, {5'h0, MODE_BYPASS});
        w(ADDR_WM_HIGH, 8'h10);
        w(ADDR_MODE, {2'h1, 3'h0, MODE_CONT});
        asel = 2'h3;
        for (int i = 0; i < 4; i++)
            pulse(1'b1, 1'b0, 8'h80);
        cnt(10'h002);
        rword(TAG_ACC, 8'h80, 0);
        rword(TAG_TS, 8'h00, 0);
        @(posedge clk);
        #1;
        chg = 1'b1;
        @(posedge clk);
        #1;
        chg = 1'b0;
        cnt(10'h001);
        rdc(ADDR_TAG, TAG_CFG);
    endtask

    initial
    begin
        {rst, acc, gyr, wake, fall, ori, chg} = 7'h40;
        {tsel, asel} = 4'h1;
        ts = 32'h0;
        smp = '0;
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        do_reset();
        t_reset();
        t_fill();
        t_cont();
        t_trig();
        t_batch();
        t_rate();
        test_done();
    end
endmodule

`default_nettype wire
